/* File: rses_flash_unit.sv */
`timescale 1ns/100ps
`default_nettype none
module rses_flash_unit
(
    input wire logic clock,
    input wire logic strobe,
    input wire logic line_read,
    output logic [31:0] reads = '0,
    output logic [31:0] lit = '0
);
    always_ff @(posedge clock)
    begin
        // lamp at full output every strobe cycle, no ramp
        lit <= lit + 32'(strobe === 1'b1);
        reads <= reads + 32'(line_read === 1'b1);
    end
endmodule
`default_nettype wire

/* File: rses_pkg.sv */
// How it works
// - staggered mode: every line integrates exactly the programmed exposure time
// - one shared readout path, never more than one line read at once
// - staggered mode: line 2 starts one line readout time after line 1
// - staggered mode: delayed starts repeat from first to last line
// - staggered optimal strobe: last line start to first line end
// - pulse_at_exposure_begin: strobe after pulse delay, held for pulse length
// - optimal delay and length computed for any exposure and vertical crop/offset
// - user strobe delay and length are used as given
// - simultaneous mode: all lines start integrating together
// - simultaneous mode: only first line gets exactly the programmed exposure
// - simultaneous mode: each line exposes one readout time longer than previous
// - simultaneous optimal strobe equals first line integration period
// - frame readout time is line readout time times line count
// - line readout interval is 20 microseconds
// - exposure time changes refused while acquisition is active
package rses_pkg;
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int LINE_READOUT_US = 20;
    localparam int LINE_READOUT_CYCLES = (LINE_READOUT_US * 1000) / CLOCK_PERIOD_NS;
    localparam int LINE_W = 12;
    localparam int TIME_W = 32;
    localparam logic MODE_STAGGERED = 1'h0;
    localparam logic MODE_SIMULTANEOUS = 1'h1;
    localparam logic [1:0] SRC_OFF = 2'h0;
    localparam logic [1:0] SRC_PULSE_AT_EXPOSURE_BEGIN = 2'h1;
    localparam logic [31:0] EXPOSURE_RESET = 32'h00004E20;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_RUN = 2'h1
    } rses_state_t;
endpackage

/* File: rses_top.sv */
`timescale 1ns/100ps
`default_nettype none
module rses_top
#(
    parameter int LINE_W = rses_pkg::LINE_W,
    parameter int TIME_W = rses_pkg::TIME_W,
    parameter int LINE_READOUT_CYCLES = rses_pkg::LINE_READOUT_CYCLES
)
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic FRAME_TRIGGER,
    input wire logic ACQUISITION_ACTIVE,
    input wire logic MODE_SELECT,
    input wire logic [LINE_W-1:0] LINE_COUNT,
    input wire logic [LINE_W-1:0] LINE_OFFSET,
    input wire logic [1:0] OUTPUT_SOURCE_SELECT,
    input wire logic [TIME_W-1:0] STROBE_PULSE_DELAY,
    input wire logic [TIME_W-1:0] STROBE_PULSE_LENGTH,
    input wire logic EXPOSURE_WRITE,
    input wire logic [TIME_W-1:0] EXPOSURE_VALUE,
    output logic [TIME_W-1:0] EXPOSURE_TIME,
    output logic EXPOSURE_REFUSED,
    output logic FRAME_BUSY,
    output logic ALL_LINES_START,
    output logic LINE_START,
    output logic [LINE_W-1:0] LINE_START_INDEX,
    output logic LINE_READ,
    output logic [LINE_W-1:0] LINE_READ_INDEX,
    output logic READOUT_BUSY,
    output logic STROBE,
    output logic [TIME_W-1:0] OPTIMAL_STROBE_DELAY,
    output logic [TIME_W-1:0] OPTIMAL_STROBE_LENGTH,
    output logic [TIME_W-1:0] FRAME_READOUT_TIME
);
    import rses_pkg::*;

    localparam int PH_W = $clog2(LINE_READOUT_CYCLES + 1);
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(LINE_READOUT_CYCLES - 1);
    localparam logic [TIME_W-1:0] RO_TIME = TIME_W'(LINE_READOUT_CYCLES);

    typedef struct packed
    {
        rses_state_t state;
        logic [TIME_W-1:0] t;
        logic [TIME_W-1:0] exposure;
        logic refused;

        // settings latched at trigger
        logic mode;
        logic [TIME_W-1:0] tint;
        logic [LINE_W-1:0] nlines;
        logic [LINE_W-1:0] offset;
        logic [1:0] src;
        logic [TIME_W-1:0] sdly;
        logic [TIME_W-1:0] slen;

        // line start sequencer
        logic starting;
        logic [LINE_W-1:0] start_line;
        logic [PH_W-1:0] start_ph;

        // readout sequencer
        logic reading;
        logic read_done;
        logic [LINE_W-1:0] read_line;
        logic [PH_W-1:0] read_ph;

        // one-cycle pulses and strobe
        logic all_start;
        logic line_start;
        logic line_read;
        logic strobe;

        // live optimal window and frame time
        logic [TIME_W-1:0] opt_dly;
        logic [TIME_W-1:0] opt_len;
        logic [TIME_W-1:0] frame_ro;
    } rses_regs_t;

    rses_regs_t s;
    rses_regs_t next_s;

    // window test written as a difference so delay plus length never overflows
    function automatic logic in_window(input logic [TIME_W-1:0] tv,
                                       input logic [TIME_W-1:0] d,
                                       input logic [TIME_W-1:0] l);
        in_window = (tv >= d) && ((tv - d) < l);
    endfunction

    // saturating difference, used where a crop may outgrow the exposure
    function automatic logic [TIME_W-1:0] clamp_sub(input logic [TIME_W-1:0] a,
                                                    input logic [TIME_W-1:0] b);
        clamp_sub = (a > b) ? (a - b) : '0;
    endfunction

    logic [LINE_W-1:0] lines_eff;
    logic [TIME_W-1:0] span;
    logic [TIME_W-1:0] t_next;
    logic start_phase_end;
    logic read_phase_end;
    logic last_line_read;
    logic exposure_due;
    logic src_pulse;
    logic strobe_window;
    logic strobe_pending;
    logic frame_done;
    logic [TIME_W-1:0] stag_opt_dly;
    logic [TIME_W-1:0] stag_opt_len;
    logic [TIME_W-1:0] sim_opt_dly;
    logic [TIME_W-1:0] sim_opt_len;

    always_comb
    begin
        lines_eff = (LINE_COUNT == '0) ? LINE_W'(1) : LINE_COUNT;
        // start of last line relative to first line start
        span = TIME_W'(lines_eff - LINE_W'(1)) * RO_TIME;
        t_next = s.t + TIME_W'(1);
        start_phase_end = (s.start_ph == PH_LAST);
        read_phase_end = (s.read_ph == PH_LAST);
        last_line_read = (s.read_line + LINE_W'(1) == s.nlines);
        // first readout falls due once the latched exposure has run out
        exposure_due = !s.reading && !s.read_done && (t_next == s.tint);
        src_pulse = (s.src == SRC_PULSE_AT_EXPOSURE_BEGIN);
        strobe_window = in_window(t_next, s.sdly, s.slen);
        // pulse not begun yet: closing the frame now would swallow it
        strobe_pending = src_pulse && (t_next < s.sdly);
        frame_done = 1'b0;
        stag_opt_dly = span;
        stag_opt_len = clamp_sub(s.exposure, span);
        sim_opt_dly = '0;
        sim_opt_len = s.exposure;

        next_s = s;
        next_s.refused = 1'b0;
        next_s.all_start = 1'b0;
        next_s.line_start = 1'b0;
        next_s.line_read = 1'b0;

        // refused writes leave the register untouched
        if (EXPOSURE_WRITE)
        begin
            if (ACQUISITION_ACTIVE)
            begin
                next_s.refused = 1'b1;
            end
            else
            begin
                next_s.exposure = EXPOSURE_VALUE;
            end
        end

        if (MODE_SELECT == MODE_STAGGERED)
        begin
            next_s.opt_dly = stag_opt_dly;
            next_s.opt_len = stag_opt_len;
        end
        else
        begin
            next_s.opt_dly = sim_opt_dly;
            next_s.opt_len = sim_opt_len;
        end
        // full frame readout for the current crop
        next_s.frame_ro = TIME_W'(lines_eff) * RO_TIME;

        case (s.state)
            ST_IDLE:
            begin
                if (FRAME_TRIGGER)
                begin
                    next_s.state = ST_RUN;
                    next_s.t = '0;
                    // settings are latched so a running frame ignores live changes
                    next_s.mode = MODE_SELECT;
                    // zero exposure would never match t_next, so readout would wait for t to wrap
                    next_s.tint = (s.exposure == '0) ? TIME_W'(1) : s.exposure;
                    next_s.nlines = lines_eff;
                    next_s.offset = LINE_OFFSET;
                    next_s.src = OUTPUT_SOURCE_SELECT;
                    next_s.sdly = STROBE_PULSE_DELAY;
                    next_s.slen = STROBE_PULSE_LENGTH;
                    next_s.start_line = '0;
                    next_s.start_ph = '0;
                    next_s.reading = 1'b0;
                    next_s.read_done = 1'b0;
                    next_s.read_line = '0;
                    next_s.read_ph = '0;
                    if (MODE_SELECT == MODE_SIMULTANEOUS)
                    begin
                        next_s.all_start = 1'b1;
                        next_s.starting = 1'b0;
                    end
                    else
                    begin
                        next_s.line_start = 1'b1;
                        next_s.starting = (lines_eff != LINE_W'(1));
                    end
                    next_s.strobe = (OUTPUT_SOURCE_SELECT == SRC_PULSE_AT_EXPOSURE_BEGIN) &&
                        in_window('0, STROBE_PULSE_DELAY, STROBE_PULSE_LENGTH);
                end
            end
            ST_RUN:
            begin
                next_s.t = t_next;
                if (s.starting)
                begin
                    if (start_phase_end)
                    begin
                        // next line waits one full readout of the line before it
                        next_s.start_ph = '0;
                        next_s.start_line = s.start_line + LINE_W'(1);
                        next_s.line_start = 1'b1;
                        next_s.starting = (s.start_line + LINE_W'(2) != s.nlines);
                    end
                    else
                    begin
                        next_s.start_ph = s.start_ph + PH_W'(1);
                    end
                end
                // readout of line k at tint + k*readout in both modes: staggered
                // lines thus all see tint, simultaneous ones grow by one readout
                if (exposure_due)
                begin
                    next_s.reading = 1'b1;
                    next_s.read_line = '0;
                    next_s.read_ph = '0;
                    next_s.line_read = 1'b1;
                end
                else if (s.reading)
                begin
                    if (read_phase_end)
                    begin
                        next_s.read_ph = '0;
                        if (last_line_read)
                        begin
                            next_s.reading = 1'b0;
                            next_s.read_done = 1'b1;
                        end
                        else
                        begin
                            next_s.read_line = s.read_line + LINE_W'(1);
                            next_s.line_read = 1'b1;
                        end
                    end
                    else
                    begin
                        next_s.read_ph = s.read_ph + PH_W'(1);
                    end
                end
                next_s.strobe = src_pulse && strobe_window;
                // frame ends only once a pending strobe pulse has run out
                frame_done = s.read_done && !next_s.strobe && !strobe_pending;
                if (frame_done)
                begin
                    next_s.state = ST_IDLE;
                    next_s.strobe = 1'b0;
                end
            end
            default:
            begin
                next_s.state = ST_IDLE;
                next_s.strobe = 1'b0;
                // unknown state: park idle with both sequencers cleared
                next_s.starting = 1'b0;
                next_s.reading = 1'b0;
                next_s.read_done = 1'b0;
                next_s.start_line = '0;
                next_s.read_line = '0;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            // exposure and its derived length come out of reset non-zero
            s <= '0;
            s.state <= ST_IDLE;
            s.exposure <= TIME_W'(EXPOSURE_RESET);
            s.opt_len <= TIME_W'(EXPOSURE_RESET);
        end
        else
        begin
            s <= next_s;
        end
    end

    assign EXPOSURE_TIME = s.exposure;
    assign EXPOSURE_REFUSED = s.refused;
    assign FRAME_BUSY = (s.state == ST_RUN);
    assign ALL_LINES_START = s.all_start;
    assign LINE_START = s.line_start;
    assign LINE_START_INDEX = s.offset + s.start_line;
    assign LINE_READ = s.line_read;
    assign LINE_READ_INDEX = s.offset + s.read_line;
    assign READOUT_BUSY = s.reading;
    assign STROBE = s.strobe;
    assign OPTIMAL_STROBE_DELAY = s.opt_dly;
    assign OPTIMAL_STROBE_LENGTH = s.opt_len;
    assign FRAME_READOUT_TIME = s.frame_ro;
endmodule
`default_nettype wire

/* File: rses_top_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module rses_top_properties
#(
    parameter int LINE_W = 12,
    parameter int TIME_W = 32,
    parameter int LINE_READOUT_CYCLES = 400
)
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic FRAME_TRIGGER,
    input wire logic ACQUISITION_ACTIVE,
    input wire logic MODE_SELECT,
    input wire logic [LINE_W-1:0] LINE_COUNT,
    input wire logic [TIME_W-1:0] STROBE_PULSE_DELAY,
    input wire logic [TIME_W-1:0] STROBE_PULSE_LENGTH,
    input wire logic EXPOSURE_WRITE,
    input wire logic [TIME_W-1:0] EXPOSURE_VALUE,
    input wire logic [TIME_W-1:0] EXPOSURE_TIME,
    input wire logic EXPOSURE_REFUSED,
    input wire logic FRAME_BUSY,
    input wire logic ALL_LINES_START,
    input wire logic LINE_START,
    input wire logic LINE_READ,
    input wire logic READOUT_BUSY,
    input wire logic STROBE,
    input wire logic [TIME_W-1:0] OPTIMAL_STROBE_DELAY,
    input wire logic [TIME_W-1:0] OPTIMAL_STROBE_LENGTH,
    input wire logic [TIME_W-1:0] FRAME_READOUT_TIME
);
    localparam logic [31:0] R = 32'(LINE_READOUT_CYCLES);
    logic [31:0] n, s, e, rg, sg, hc, fc, dl, ln, od, ol, fr;
    logic bq, ok;
    always_comb
    begin
        n = (LINE_COUNT == '0) ? 32'h1 : 32'(LINE_COUNT);
        s = (n - 32'h1) * R;
        e = 32'(EXPOSURE_TIME);
    end
    // gap counters read 1 on the cycle after a pulse
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            {rg, sg, hc, fc, dl, ln, od, ol, fr, bq, ok} <= '0;
        end
        else
        begin
            ok <= 1'b1;
            rg <= LINE_READ ? 32'h1 : rg + 32'h1;
            sg <= LINE_START ? 32'h1 : sg + 32'h1;
            hc <= STROBE ? hc + 32'h1 : '0;
            bq <= FRAME_BUSY;
            fc <= (FRAME_BUSY && !bq) ? 32'h1 : fc + 32'h1;
            if (FRAME_TRIGGER && !FRAME_BUSY)
            begin
                dl <= 32'(STROBE_PULSE_DELAY);
                ln <= 32'(STROBE_PULSE_LENGTH);
            end
            fr <= s + R;
            od <= MODE_SELECT ? '0 : s;
            ol <= MODE_SELECT ? e : ((e > s) ? e - s : '0);
        end
    end
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);
    a_read_gap: assert property (LINE_READ && $past(READOUT_BUSY) |-> rg == R)
        else $error("read gap");
    a_start_gap: assert property (LINE_START && !$rose(FRAME_BUSY) |-> sg == R)
        else $error("start gap");
    a_start_kind: assert property (ALL_LINES_START |-> !LINE_START && $rose(FRAME_BUSY))
        else $error("start kind");
    a_frame_ro: assert property (ok |-> FRAME_READOUT_TIME == fr)
        else $error("frame time");
    a_opt_strobe: assert property (ok |-> OPTIMAL_STROBE_DELAY == od && OPTIMAL_STROBE_LENGTH == ol)
        else $error("optimal strobe");
    a_exp_refuse: assert property (EXPOSURE_WRITE && ACQUISITION_ACTIVE |=> EXPOSURE_REFUSED && $stable(EXPOSURE_TIME))
        else $error("write not refused");
    a_exp_take: assert property (EXPOSURE_WRITE && !ACQUISITION_ACTIVE && !FRAME_BUSY |=> EXPOSURE_TIME == $past(EXPOSURE_VALUE))
        else $error("write lost");
    a_strobe_len: assert property ($fell(STROBE) |-> hc == ln)
        else $error("strobe length");
    a_strobe_dly: assert property ($rose(STROBE) && !$rose(FRAME_BUSY) |-> fc == dl)
        else $error("strobe delay");
endmodule
bind rses_top rses_top_properties #(.LINE_W(LINE_W), .TIME_W(TIME_W),
    .LINE_READOUT_CYCLES(LINE_READOUT_CYCLES)) u_props (.CLOCK(CLOCK), .RSTN(RSTN),
    .FRAME_TRIGGER(FRAME_TRIGGER), .ACQUISITION_ACTIVE(ACQUISITION_ACTIVE),
    .MODE_SELECT(MODE_SELECT), .LINE_COUNT(LINE_COUNT),
    .STROBE_PULSE_DELAY(STROBE_PULSE_DELAY), .STROBE_PULSE_LENGTH(STROBE_PULSE_LENGTH),
    .EXPOSURE_WRITE(EXPOSURE_WRITE), .EXPOSURE_VALUE(EXPOSURE_VALUE),
    .EXPOSURE_TIME(EXPOSURE_TIME), .EXPOSURE_REFUSED(EXPOSURE_REFUSED),
    .FRAME_BUSY(FRAME_BUSY), .ALL_LINES_START(ALL_LINES_START), .LINE_START(LINE_START),
    .LINE_READ(LINE_READ), .READOUT_BUSY(READOUT_BUSY), .STROBE(STROBE),
    .OPTIMAL_STROBE_DELAY(OPTIMAL_STROBE_DELAY),
    .OPTIMAL_STROBE_LENGTH(OPTIMAL_STROBE_LENGTH), .FRAME_READOUT_TIME(FRAME_READOUT_TIME));
`default_nettype wire

/* File: tb_rses_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_rses_top;
    localparam int R = 4;
    logic CLOCK = 0, RSTN = 0, trig = 0, acq = 0, mode = 0, wr = 0, rf, busy, als, ls, strb, lr;
    logic [11:0] lc = '0;
    logic [1:0] src = '0;
    logic [31:0] dly = '0, len = '0, ev = '0, et, od, ol, fr, reads, lit;
    int n_errors = 0, tests_run = 0, cyc = 0, n_ls = 0, n_als = 0, n_lr = 0, n_rb = 0, t0 = 0;
    logic [11:0] lsi, lri;
    logic rb;
    rses_top #(.LINE_READOUT_CYCLES(R)) dut (.CLOCK(CLOCK), .RSTN(RSTN),
        .FRAME_TRIGGER(trig), .ACQUISITION_ACTIVE(acq), .MODE_SELECT(mode),
        .LINE_COUNT(lc), .LINE_OFFSET(12'h5), .OUTPUT_SOURCE_SELECT(src),
        .STROBE_PULSE_DELAY(dly), .STROBE_PULSE_LENGTH(len), .EXPOSURE_WRITE(wr),
        .EXPOSURE_VALUE(ev), .EXPOSURE_TIME(et), .EXPOSURE_REFUSED(rf), .FRAME_BUSY(busy),
        .ALL_LINES_START(als), .LINE_START(ls), .LINE_START_INDEX(lsi), .LINE_READ(lr),
        .LINE_READ_INDEX(lri), .READOUT_BUSY(rb), .STROBE(strb), .OPTIMAL_STROBE_DELAY(od),
        .OPTIMAL_STROBE_LENGTH(ol), .FRAME_READOUT_TIME(fr));
    rses_flash_unit flash (.clock(CLOCK), .strobe(strb), .line_read(lr), .reads(reads),
        .lit(lit));
    initial
    begin
        forever #25 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK)
    begin
        cyc++;
        if ((ls === 1'b1 || als === 1'b1) && n_ls == 0 && n_als == 0)
            t0 = cyc;
        if (ls === 1'b1)
            chk(32'(lsi), 32'(5 + n_ls));
        if (lr === 1'b1)
        begin
            if (n_lr == 0)
                chk(32'(cyc - t0), 32'd20);
            chk(32'(lri), 32'(5 + n_lr));
            n_lr++;
        end
        n_rb += int'(rb === 1'b1);
        n_ls += int'(ls === 1'b1);
        n_als += int'(als === 1'b1);
        if (cyc == 3000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr_exp(input logic a, input logic [31:0] v);
        @(posedge CLOCK);
        acq <= a;
        wr <= 1'b1;
        ev <= v;
        @(posedge CLOCK);
        wr <= 1'b0;
        #1;
        chk({31'h0, rf}, {31'h0, a});
    endtask
    task automatic frame(input logic m, input int d, input int l, input int nl);
        int r0, l0, w;
        @(posedge CLOCK);
        mode <= m;
        lc <= 12'(nl);
        src <= 2'h1;
        dly <= 32'(d);
        len <= 32'(l);
        trig <= 1'b1;
        r0 = int'(reads);
        l0 = int'(lit);
        w = 0;
        n_ls = 0;
        n_als = 0;
        n_lr = 0;
        n_rb = 0;
        @(posedge CLOCK);
        trig <= 1'b0;
        #1;
        while (busy === 1'b1 && w < 500)
        begin
            @(posedge CLOCK);
            #1;
            w++;
        end
        chk(32'(w < 500), 32'h1);
        chk(32'(n_rb), 32'(nl * R));
        chk(reads - 32'(r0), 32'(nl));
        chk(lit - 32'(l0), 32'(l));
        chk(32'(n_ls), m ? 32'h0 : 32'(nl));
        chk(32'(n_als), {31'h0, m});
        chk(od, m ? 32'h0 : 32'((nl - 1) * R));
        chk(ol, m ? 32'd20 : 32'(20 - (nl - 1) * R));
        chk(fr, 32'(nl * R));
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge CLOCK);
        RSTN <= 1'b1;
        #1;
        chk(et, 32'h4E20);
        wr_exp(1'b0, 32'd20);
        chk(et, 32'd20);
        wr_exp(1'b1, 32'd7);
        chk(et, 32'd20);
        frame(1'b0, 8, 12, 3);
        frame(1'b1, 0, 20, 3);
        frame(1'b0, 1, 2, 1);
        frame(1'b1, 3, 5, 4);
        wrap_up();
    end
endmodule
`default_nettype wire
